//--- logic/asrp_device.sv
// Notes on behaviour
// - device acts only while select is low
// - input bit sampled on serial clock rise
// - no timeout; state held at any rate
// - one access is exactly 24 bits
// - most significant bit first, both directions
// - header 010 writes, 110 reads
// - five address bits follow header, top first
// - write stores last 16 bits at address
// - read ignores input, shifts register out
// - decode address map 01h upward, revision
// - host avoids access during calibration
// - registers read/write with defined reset values
//
// serial register port, device end: register file behind a 24-bit frame decoder
// assumes: pins arrive asynchronously and are synchronised on clk_sys; the
// serial clock is at least several clk_sys periods per phase
`timescale 1ns/1ps
`include "asrp_regs.svh"

module asrp_device #(
   parameter logic [15:0] REVISION = `ASRP_REVISION_VALUE, // arbitrary value
   parameter int NUM_RW = 20
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   // serial pins
   asrp_if.dev link,
   // register contents, entry k holds address k+1
   output logic [NUM_RW*16-1:0] reg_contents,
   // write notification
   output logic reg_write_pulse,
   output logic [4:0] reg_write_addr,
   // status
   output logic frame_active
);
   // ****************************************
   // pin synchronisation
   // ****************************************
   logic [2:0] pins_sync;
   logic sclk_s;
   logic sel_n_s;
   logic sin_s;
   logic sclk_prev_reg;
   logic rise;
   logic fall;

   asrp_sync #(
      .WIDTH(3),
      .RESET_VAL(3'h2)
   ) u_sync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .pin_in({link.serial_clk, link.port_select_n, link.serial_in}),
      .pin_sync(pins_sync)
   );

   assign sclk_s = pins_sync[2];
   assign sel_n_s = pins_sync[1];
   assign sin_s = pins_sync[0];

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sclk_prev_reg <= 1'b0;
      end else if (clk_en) begin
         sclk_prev_reg <= sclk_s;
      end
   end

   // edges only count while selected; no time-out anywhere
   assign rise = sclk_s & ~sclk_prev_reg & ~sel_n_s;
   assign fall = ~sclk_s & sclk_prev_reg & ~sel_n_s;

   // ****************************************
   // frame shifter
   // ****************************************
   logic [4:0] bit_cnt_reg;
   logic [22:0] shift_reg;
   logic [23:0] frame_word;
   logic [2:0] hdr_now;
   logic [4:0] addr_now;
   logic [2:0] op_reg;
   logic [4:0] addr_reg;

   assign frame_word = {shift_reg, sin_s};
   assign hdr_now = frame_word[7:5];
   assign addr_now = frame_word[4:0];

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         bit_cnt_reg <= 5'h00;
         shift_reg <= 23'h000000;
      end else if (clk_en) begin
         if (sel_n_s) begin
            bit_cnt_reg <= 5'h00;
         end else if (rise && bit_cnt_reg != 5'(`ASRP_FRAME_BITS)) begin
            // bits beyond the 24th are dropped until the next select
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            shift_reg <= frame_word[22:0];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         op_reg <= 3'h0;
         addr_reg <= 5'h00;
      end else if (clk_en) begin
         if (rise && bit_cnt_reg == 5'(`ASRP_HDR_ADDR_BITS - 1)) begin
            op_reg <= hdr_now;
            addr_reg <= addr_now;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         frame_active <= 1'b0;
      end else if (clk_en) begin
         frame_active <= ~sel_n_s;
      end
   end

   // ****************************************
   // register file
   // ****************************************
   logic [15:0] regs_mem [`ASRP_ADDR_FIRST_RW:`ASRP_ADDR_LAST_RW];
   logic write_hit;
   logic [15:0] read_value;

   function automatic logic rw_addr(input logic [4:0] a);
      rw_addr = a >= `ASRP_ADDR_FIRST_RW && a <= `ASRP_ADDR_LAST_RW
                && a != `ASRP_ADDR_RESERVED_SLOT;
   endfunction

   // write lands only on the 24th bit, so an aborted frame leaves all intact
   assign write_hit = rise && bit_cnt_reg == 5'(`ASRP_FRAME_BITS - 1)
                      && op_reg == `ASRP_OP_WRITE && rw_addr(addr_reg);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = `ASRP_ADDR_FIRST_RW; i <= `ASRP_ADDR_LAST_RW; i++) begin
            regs_mem[i] <= `ASRP_POR_OTHER;
         end
         regs_mem[`ASRP_ADDR_MAIN_CONFIGURATION_A] <= `ASRP_POR_MAIN_CONFIGURATION_A;
      end else if (clk_en && write_hit) begin
         regs_mem[addr_reg] <= frame_word[15:0];
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         reg_write_pulse <= 1'b0;
         reg_write_addr <= 5'h00;
      end else if (clk_en) begin
         reg_write_pulse <= write_hit;
         if (write_hit) begin
            reg_write_addr <= addr_reg;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_RW; g++) begin : g_out
         assign reg_contents[g*16 +: 16] = regs_mem[g + 1];
      end
   endgenerate

   // reserved and unmapped addresses read as zero
   always_comb begin
      read_value = 16'h0000;
      if (rw_addr(addr_now)) begin
         read_value = regs_mem[addr_now];
      end else if (addr_now == `ASRP_ADDR_REVISION) begin
         read_value = REVISION;
      end
   end

   // ****************************************
   // read-data shifter
   // ****************************************
   logic [15:0] out_shift_reg;
   logic rd_active_reg;
   logic [4:0] out_left_reg;

   // first data bit is presented right after the 8th rise and held over the
   // fall that follows it; each later fall moves on one bit, so the master
   // finds bit 15 at the 9th rise and bit 0 at the 24th
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         out_shift_reg <= 16'h0000;
         rd_active_reg <= 1'b0;
         out_left_reg <= 5'h00;
      end else if (clk_en) begin
         if (sel_n_s) begin
            rd_active_reg <= 1'b0;
         end else if (rise && bit_cnt_reg == 5'(`ASRP_HDR_ADDR_BITS - 1)
                      && hdr_now == `ASRP_OP_READ) begin
            out_shift_reg <= read_value;
            rd_active_reg <= 1'b1;
            out_left_reg <= 5'(`ASRP_DATA_BITS);
         end else if (fall && rd_active_reg) begin
            if (out_left_reg == 5'h00) begin
               rd_active_reg <= 1'b0;
            end else begin
               if (out_left_reg != 5'(`ASRP_DATA_BITS)) begin
                  out_shift_reg <= {out_shift_reg[14:0], 1'b0};
               end
               out_left_reg <= out_left_reg - 5'h01;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         link.serial_out <= 1'b1;
         link.serial_out_oe_n <= 1'b1;
      end else if (clk_en) begin
         link.serial_out <= out_shift_reg[15];
         link.serial_out_oe_n <= ~(rd_active_reg & ~sel_n_s);
      end
   end
endmodule

//--- logic/asrp_host.sv
// serial register port, master end: runs one 24-bit frame per command
// assumes: software drives the plain register port; the device synchronises
// pins, so a half period of at least eight system clocks is enforced
`timescale 1ns/1ps
`include "asrp_regs.svh"

module asrp_host (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   // register port
   input wire logic [7:0] cmd_addr,
   input wire logic [31:0] cmd_wdata,
   input wire logic cmd_write,
   input wire logic cmd_read,
   output logic [31:0] cmd_rdata,
   // serial pins
   asrp_if.host link
);
   // ****************************************
   // registers
   // ****************************************
   asrp_pkg::asrp_host_state_t state_reg;
   logic [15:0] half_reg;
   logic [15:0] timer_reg;
   logic [23:0] tx_reg;
   logic [15:0] rx_reg;
   logic [15:0] rdata_reg;
   logic [4:0] bit_cnt_reg;
   logic is_read_reg;
   logic done_reg;
   logic so_s;
   logic start;
   logic tick;
   logic frame_end;

   asrp_sync #(
      .WIDTH(1),
      .RESET_VAL(1'b1)
   ) u_sync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .pin_in(link.serial_out_line),
      .pin_sync(so_s)
   );

   assign start = cmd_write && cmd_addr == `ASRP_HOST_CMD && state_reg == asrp_pkg::ASRP_H_IDLE;
   assign tick = timer_reg == 16'h0000;
   assign frame_end = tick && state_reg == asrp_pkg::ASRP_H_GAP;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         half_reg <= `ASRP_HALF_DEFAULT;
      end else if (clk_en && cmd_write && cmd_addr == `ASRP_HOST_DIV) begin
         // too short a half period would outrun the device's synchroniser
         half_reg <= cmd_wdata[15:0] < `ASRP_HALF_MIN ? `ASRP_HALF_MIN : cmd_wdata[15:0];
      end
   end

   // done: set by frame end, cleared by writing one; the set wins
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         done_reg <= 1'b0;
      end else if (clk_en) begin
         if (frame_end) begin
            done_reg <= 1'b1;
         end else if (cmd_write && cmd_addr == `ASRP_HOST_STATUS
                      && cmd_wdata[`ASRP_STAT_DONE_BIT]) begin
            done_reg <= 1'b0;
         end
      end
   end

   // ****************************************
   // frame sequencer
   // ****************************************
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= asrp_pkg::ASRP_H_IDLE;
         timer_reg <= 16'h0000;
         tx_reg <= 24'h000000;
         rx_reg <= 16'h0000;
         rdata_reg <= 16'h0000;
         bit_cnt_reg <= 5'h00;
         is_read_reg <= 1'b0;
      end else if (clk_en) begin
         if (!tick) begin
            timer_reg <= timer_reg - 16'h0001;
         end
         unique case (state_reg)
            asrp_pkg::ASRP_H_IDLE: begin
               if (start) begin
                  is_read_reg <= cmd_wdata[`ASRP_CMD_READ_BIT];
                  tx_reg <= {cmd_wdata[`ASRP_CMD_READ_BIT] ? `ASRP_OP_READ : `ASRP_OP_WRITE,
                             cmd_wdata[`ASRP_CMD_ADDR_LSB +: 5], cmd_wdata[15:0]};
                  bit_cnt_reg <= 5'h00;
                  timer_reg <= half_reg;
                  state_reg <= asrp_pkg::ASRP_H_LOW;
               end
            end
            asrp_pkg::ASRP_H_LOW: begin
               if (tick) begin
                  if (is_read_reg && bit_cnt_reg >= 5'(`ASRP_HDR_ADDR_BITS)) begin
                     rx_reg <= {rx_reg[14:0], so_s};
                  end
                  timer_reg <= half_reg;
                  state_reg <= asrp_pkg::ASRP_H_HIGH;
               end
            end
            asrp_pkg::ASRP_H_HIGH: begin
               if (tick) begin
                  timer_reg <= half_reg;
                  if (bit_cnt_reg == 5'(`ASRP_FRAME_BITS - 1)) begin
                     state_reg <= asrp_pkg::ASRP_H_TAIL;
                  end else begin
                     bit_cnt_reg <= bit_cnt_reg + 5'h01;
                     tx_reg <= {tx_reg[22:0], 1'b0};
                     state_reg <= asrp_pkg::ASRP_H_LOW;
                  end
               end
            end
            asrp_pkg::ASRP_H_TAIL: begin
               if (tick) begin
                  timer_reg <= half_reg;
                  if (is_read_reg) begin
                     rdata_reg <= rx_reg;
                  end
                  state_reg <= asrp_pkg::ASRP_H_GAP;
               end
            end
            asrp_pkg::ASRP_H_GAP: begin
               if (tick) begin
                  state_reg <= asrp_pkg::ASRP_H_IDLE;
               end
            end
            default: begin
               state_reg <= asrp_pkg::ASRP_H_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // pins and read-back
   // ****************************************
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         link.port_select_n <= 1'b1;
         link.serial_clk <= 1'b0;
         link.serial_in <= 1'b0;
      end else if (clk_en) begin
         // select spans the whole frame including the final low phase
         link.port_select_n <= state_reg == asrp_pkg::ASRP_H_IDLE
                               || state_reg == asrp_pkg::ASRP_H_GAP;
         link.serial_clk <= state_reg == asrp_pkg::ASRP_H_HIGH;
         link.serial_in <= tx_reg[23];
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cmd_rdata <= 32'h00000000;
      end else if (clk_en) begin
         cmd_rdata <= 32'h00000000;
         if (cmd_read) begin
            unique case (cmd_addr)
               `ASRP_HOST_STATUS: begin
                  cmd_rdata <= {30'h00000000, done_reg, state_reg != asrp_pkg::ASRP_H_IDLE};
               end
               `ASRP_HOST_RDATA: begin
                  cmd_rdata <= {16'h0000, rdata_reg};
               end
               `ASRP_HOST_DIV: begin
                  cmd_rdata <= {16'h0000, half_reg};
               end
               default: begin
                  cmd_rdata <= 32'h00000000;
               end
            endcase
         end
      end
   end
endmodule

//--- logic/asrp_if.sv
// pins between the serial master and the register port
// assumes: the data-out pin is pulled high while the device does not drive it
`timescale 1ns/1ps

interface asrp_if;
   logic port_select_n;
   logic serial_clk;
   logic serial_in;
   logic serial_out;
   logic serial_out_oe_n;
   logic serial_out_line;

   // pull-up model of the shared data-out wire
   assign serial_out_line = serial_out_oe_n ? 1'b1 : serial_out;

   modport dev (
      input port_select_n,
      input serial_clk,
      input serial_in,
      output serial_out,
      output serial_out_oe_n
   );

   modport host (
      output port_select_n,
      output serial_clk,
      output serial_in,
      input serial_out_line
   );
endinterface

//--- logic/asrp_pkg.sv
// types shared by both ends of the serial register port
// assumes: constants come from asrp_regs.svh
`include "asrp_regs.svh"

package asrp_pkg;

   typedef enum logic [2:0] {
      ASRP_OP_WR_T = `ASRP_OP_WRITE,
      ASRP_OP_RD_T = `ASRP_OP_READ
   } asrp_op_t;

   typedef enum logic [2:0] {
      ASRP_H_IDLE = 3'h0,
      ASRP_H_LOW = 3'h1,
      ASRP_H_HIGH = 3'h2,
      ASRP_H_TAIL = 3'h3,
      ASRP_H_GAP = 3'h4
   } asrp_host_state_t;

endpackage

//--- logic/asrp_regs.svh
// constants of the serial register port: frame layout, op codes, address map,
// reset values, controller register offsets and timing counts
// assumes: included by bare name from every design file that needs a figure
`ifndef ASRP_REGS_SVH
`define ASRP_REGS_SVH

// frame layout
`define ASRP_FRAME_BITS 24
`define ASRP_HDR_BITS 3
`define ASRP_ADDR_BITS 5
`define ASRP_DATA_BITS 16
`define ASRP_HDR_ADDR_BITS 8
`define ASRP_OP_WRITE 3'h2
`define ASRP_OP_READ 3'h6

// device address map
`define ASRP_ADDR_MAIN_CONFIGURATION_A 5'h01
`define ASRP_ADDR_MAIN_CONFIGURATION_B 5'h02
`define ASRP_ADDR_CALIBRATION_SETUP 5'h03
`define ASRP_ADDR_CHANNEL_A_GAIN_SETUP 5'h04
`define ASRP_ADDR_CHANNEL_A_OFFSET_TRIM 5'h05
`define ASRP_ADDR_CHANNEL_B_GAIN_SETUP 5'h06
`define ASRP_ADDR_CHANNEL_B_OFFSET_TRIM 5'h07
`define ASRP_ADDR_CHANNEL_C_GAIN_SETUP 5'h08
`define ASRP_ADDR_CHANNEL_C_OFFSET_TRIM 5'h09
`define ASRP_ADDR_CHANNEL_D_GAIN_SETUP 5'h0A
`define ASRP_ADDR_CHANNEL_D_OFFSET_TRIM 5'h0B
`define ASRP_ADDR_SAMPLING_APERTURE_TRIM 5'h0C
`define ASRP_ADDR_OUTPUT_TEST_PATTERN 5'h0D
`define ASRP_ADDR_CALIBRATION_SCAN 5'h0E
`define ASRP_ADDR_RESERVED_SLOT 5'h0F
`define ASRP_ADDR_LANE_ALIGNMENT_CONTROL 5'h10
`define ASRP_ADDR_LINK_SETUP_A 5'h11
`define ASRP_ADDR_LINK_SETUP_B 5'h12
`define ASRP_ADDR_LINK_SETUP_C 5'h13
`define ASRP_ADDR_LINK_SETUP_D 5'h14
`define ASRP_ADDR_REVISION 5'h1E
`define ASRP_ADDR_FIRST_RW 5'h01
`define ASRP_ADDR_LAST_RW 5'h14

// reset values
`define ASRP_POR_MAIN_CONFIGURATION_A 16'h0000
`define ASRP_POR_OTHER 16'h0000
`define ASRP_REVISION_VALUE 16'h00A5

// controller registers, byte addresses
`define ASRP_HOST_CMD 8'h00
`define ASRP_HOST_STATUS 8'h04
`define ASRP_HOST_RDATA 8'h08
`define ASRP_HOST_DIV 8'h0C
`define ASRP_CMD_READ_BIT 24
`define ASRP_CMD_ADDR_LSB 16
`define ASRP_STAT_BUSY_BIT 0
`define ASRP_STAT_DONE_BIT 1

// serial clock half period in system clocks
`define ASRP_HALF_DEFAULT 16'h0010
`define ASRP_HALF_MIN 16'h0008

`endif

//--- logic/asrp_sync.sv
// two-stage synchroniser for a group of pins
// assumes: inputs are asynchronous to clk_sys; RESET_VAL is the idle pin level
`timescale 1ns/1ps

module asrp_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   // pins in, synchronised out
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_sync
);
   logic [WIDTH-1:0] stage1_reg;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         stage1_reg <= RESET_VAL;
         pin_sync <= RESET_VAL;
      end else if (clk_en) begin
         stage1_reg <= pin_in;
         pin_sync <= stage1_reg;
      end
   end
endmodule

//--- test/asrp_asserts.sv
// checker on the serial pins between host and device
// assumes: instantiated beside the interface; every input is sampled on clk_sys
`timescale 1ns/1ps
`include "asrp_regs.svh"

module asrp_asserts (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // serial pins
   input wire logic port_select_n,
   input wire logic serial_clk,
   input wire logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_oe_n
);
   logic sclk_q;
   logic [4:0] rise_cnt;
   logic [2:0] hdr;

   default clocking dcb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   // ****************
   // frame tracking
   // ****************
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= serial_clk;
      end
   end

   // header kept until the next frame overwrites it
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rise_cnt <= 5'h00;
         hdr <= 3'h0;
      end else if (port_select_n) begin
         rise_cnt <= 5'h00;
      end else if (serial_clk && !sclk_q) begin
         rise_cnt <= rise_cnt + 5'h01;
         if (rise_cnt < 5'h03) begin
            hdr <= {hdr[1:0], serial_in};
         end
      end
   end

   // ****************
   // pin rules
   // ****************
   AST_OE_RELEASE: assert property ($rose(port_select_n) |-> ##[0:6] serial_out_oe_n)
      else $error("data out still driven after deselect");
   AST_SCLK_IDLE: assert property (port_select_n && $past(port_select_n) |-> !serial_clk)
      else $error("serial clock moves outside a frame");
   AST_FRAME_LEN: assert property ($rose(port_select_n) |-> rise_cnt == 5'h18)
      else $error("frame not 24 clocks long");
   AST_SEL_START: assert property ($fell(port_select_n) |-> !serial_clk && rise_cnt == 5'h00)
      else $error("frame starts with clock high");
   AST_IN_HELD: assert property (serial_clk && $past(serial_clk) |-> $stable(serial_in))
      else $error("data in changes while clock high");
   AST_OE_WINDOW: assert property (!serial_out_oe_n |-> rise_cnt >= 5'h08 && !port_select_n)
      else $error("data out driven outside data field");
   AST_OE_START: assert property ($fell(serial_out_oe_n) |-> rise_cnt == 5'h08 && hdr == 3'h6)
      else $error("drive starts without read header");
   AST_WRITE_QUIET: assert property (rise_cnt >= 5'h08 && hdr == 3'h2 |-> serial_out_oe_n)
      else $error("data out driven on a write");
   AST_OUT_HELD: assert property ($rose(serial_clk) && !serial_out_oe_n |=> $stable(serial_out) [*6])
      else $error("read bit changes around clock rise");
   AST_OE_END: assert property ($fell(serial_clk) && rise_cnt == 5'h18 |-> ##[1:6] serial_out_oe_n)
      else $error("data out held after last bit");
endmodule

//--- test/testbench.sv
// bench: host and device on one link; a second device bit-banged by the bench
// assumes: design files compiled first; clk_sys 250 MHz
`timescale 1ns/1ps
`include "asrp_regs.svh"

module testbench;
   localparam logic [15:0] REV = 16'h3C5A; // arbitrary value
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic clk_en = 1'b1;
   logic [7:0] cmd_addr = 8'h00;
   logic [31:0] cmd_wdata = 32'h0;
   logic cmd_write = 1'b0;
   logic cmd_read = 1'b0;
   logic [31:0] cmd_rdata;
   logic [319:0] regs_a, regs_b;
   logic pulse_a, pulse_b, act_b;
   logic [4:0] waddr_a, waddr_b;
   logic chk = 1'b0;
   logic chk_q = 1'b0;
   logic [15:0] mdl [0:31];
   logic [20:0] exp_wr [$];
   logic [31:0] exp_rd [$];
   logic [23:0] rx = 24'h0;
   int n_mismatch = 0;
   int checked = 0;
   integer seed = 12173;
   event bb_ev;

   asrp_if link_if ();
   asrp_if link_b_if ();
   always #2 clk_sys = ~clk_sys;

   asrp_host asrp_host_inst (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_write(cmd_write),
      .cmd_read(cmd_read), .cmd_rdata(cmd_rdata), .link(link_if.host));
   asrp_device #(.REVISION(REV), .NUM_RW(20)) asrp_device_inst (.clk_sys(clk_sys),
      .reset_n(reset_n), .clk_en(clk_en), .link(link_if.dev), .reg_contents(regs_a),
      .reg_write_pulse(pulse_a), .reg_write_addr(waddr_a), .frame_active());
   asrp_device #(.REVISION(REV), .NUM_RW(20)) asrp_device_inst_b (.clk_sys(clk_sys),
      .reset_n(reset_n), .clk_en(clk_en), .link(link_b_if.dev), .reg_contents(regs_b),
      .reg_write_pulse(pulse_b), .reg_write_addr(waddr_b), .frame_active(act_b));
   asrp_asserts asrp_asserts_inst (.clk_sys(clk_sys), .reset_n(reset_n),
      .port_select_n(link_if.port_select_n), .serial_clk(link_if.serial_clk),
      .serial_in(link_if.serial_in), .serial_out(link_if.serial_out),
      .serial_out_oe_n(link_if.serial_out_oe_n));

   // ****************
   // checking
   // ****************
   task automatic note(input logic ok, input string msg);
      checked++;
      if (!ok) begin
         n_mismatch++;
         $display("ERROR t=%0t %s", $time, msg);
      end
   endtask

   task automatic cmp_wr(input logic [4:0] a, input logic [319:0] r);
      logic [20:0] e;
      e = (exp_wr.size() > 0) ? exp_wr.pop_front() : 21'h1FFFFF;
      note(e === {a, r[(int'(a) - 1) * 16 +: 16]}, "write mismatch");
   endtask

   task automatic cmp_rd(input logic [31:0] got);
      logic [31:0] e;
      e = (exp_rd.size() > 0) ? exp_rd.pop_front() : 32'hFFFFFFFF;
      note(got === e, "read data mismatch");
   endtask

   always @(posedge clk_sys) chk_q <= chk && cmd_read;
   always @(negedge clk_sys) begin
      if (pulse_a === 1'b1) cmp_wr(waddr_a, regs_a);
      if (pulse_b === 1'b1) cmp_wr(waddr_b, regs_b);
      if (chk_q) cmp_rd(cmd_rdata);
   end
   always @(bb_ev) cmp_rd({16'h0000, rx[15:0]});

   task automatic summarize();
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ****************
   // drivers
   // ****************
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_write <= 1'b1;
      @(posedge clk_sys);
      cmd_write <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic c, output logic [31:0] d);
      @(posedge clk_sys);
      cmd_addr <= a;
      cmd_read <= 1'b1;
      chk <= c;
      @(posedge clk_sys);
      cmd_read <= 1'b0;
      chk <= 1'b0;
      #1;
      d = cmd_rdata;
   endtask

   // software waits on done; the bench never calibrates, so no access is off limits
   task automatic frame(input logic r, input logic [4:0] a, input logic [15:0] d);
      logic [31:0] s;
      int n;
      s = 32'h0;
      n = 0;
      wr(`ASRP_HOST_CMD, {7'h00, r, 3'h0, a, d});
      while (s[`ASRP_STAT_DONE_BIT] !== 1'b1 && n < 3000) begin
         rd(`ASRP_HOST_STATUS, 1'b0, s);
         n++;
      end
      note(n < 3000, "frame never completed");
      wr(`ASRP_HOST_STATUS, 32'h00000002);
      if (r) rd(`ASRP_HOST_RDATA, 1'b1, s);
   endtask

   task automatic do_wr(input logic [4:0] a, input logic [15:0] d);
      if (a >= `ASRP_ADDR_FIRST_RW && a <= `ASRP_ADDR_LAST_RW
          && a != `ASRP_ADDR_RESERVED_SLOT) begin
         exp_wr.push_back({a, d});
         mdl[a] = d;
      end
      frame(1'b0, a, d);
   endtask

   task automatic do_rd(input logic [4:0] a);
      exp_rd.push_back({16'h0000, mdl[a]});
      frame(1'b1, a, 16'($random(seed)));
   endtask

   task automatic clear_mdl();
      foreach (mdl[a]) mdl[a] = 16'h0000;
      mdl[`ASRP_ADDR_REVISION] = REV;
   endtask

   // bench-made serial clock, 125 ns period, unrelated to clk_sys
   task automatic bang(input logic [23:0] f, input int nb, input int stall);
      link_b_if.port_select_n = 1'b0;
      for (int i = 0; i < nb; i++) begin
         link_b_if.serial_in = f[23-i];
         #62.5;
         if (i == 0) note(act_b === 1'b1, "select low not seen");
         link_b_if.serial_clk = 1'b1;
         rx = {rx[22:0], link_b_if.serial_out_line};
         #62.5;
         link_b_if.serial_clk = 1'b0;
         if (i == stall) #2000;
      end
      #62.5;
      link_b_if.port_select_n = 1'b1;
      link_b_if.serial_in = ~link_b_if.serial_in;
      #200;
      note(act_b === 1'b0, "select high not seen");
   endtask

   // ****************
   // tests
   // ****************
   initial begin
      logic [31:0] s;
      link_b_if.port_select_n = 1'b1;
      link_b_if.serial_clk = 1'b0;
      link_b_if.serial_in = 1'b0;
      clear_mdl();
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'b1;
      // divider values below the floor are raised by the host
      s = {16'h0000, 16'($random(seed)) & 16'h000B};
      wr(`ASRP_HOST_DIV, s);
      exp_rd.push_back(s < `ASRP_HALF_MIN ? 32'(`ASRP_HALF_MIN) : s);
      rd(`ASRP_HOST_DIV, 1'b1, s);
      exp_rd.push_back(32'h0);
      rd(8'h10, 1'b1, s);
      for (int a = 0; a < 32; a++) do_rd(5'(a));
      $display("reset value test done");
      for (int a = 0; a < 32; a++) do_wr(5'(a), 16'($random(seed)));
      for (int a = 0; a < 32; a++) do_rd(5'(a));
      do_wr(5'h01, 16'h8001);
      do_rd(5'h01);
      $display("write and read test done");
      bang({3'h2, 5'h01, 16'h1234}, 23, -1);
      bang({3'h3, 5'h01, 16'h4321}, 24, -1);
      exp_wr.push_back({5'h01, 16'hA5C3});
      bang({3'h2, 5'h01, 16'hA5C3}, 24, 11);
      exp_rd.push_back({16'h0000, 16'hA5C3});
      bang({3'h6, 5'h01, 16'hFFFF}, 24, -1);
      -> bb_ev;
      $display("bit level test done");
      @(negedge clk_sys);
      reset_n = 1'b0;
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'b1;
      clear_mdl();
      do_rd(5'h01);
      do_rd(5'h14);
      $display("second reset test done");
      repeat (20) @(posedge clk_sys);
      note(exp_wr.size() == 0 && exp_rd.size() == 0, "expected result missing");
      summarize();
   end

   initial begin
      #360000;
      n_mismatch++;
      $display("ERROR t=%0t watchdog expired", $time);
      summarize();
   end
endmodule
